/* File: oag_pkg.sv */
// Functional notes
// - indexed mode adds the pointer and the signed index byte, -128 to +127
// - data space splits into system FF00-FFFF, special FE00-FEFF, RAM 0000-FDFF
// - the base pointer's area fixes the target area; displacement cannot leave it
// - RAM base displaced out of RAM reads back 0FFH without touching memory
// - special-area base keeps the low eight bits and adds 0FE00H
// - offset mode adds a signed 7-bit offset, -64 to +63, to the pointer named by ptr_num
// - direct mode takes the address from the operand, short or long forms
// - table word load reads two program bytes via pointer, indexed or offset
// - table word load uses a 17-bit pointer whose bit 16 is the RAM-bit-8 flag
// - bank flag, status bit 3, picks the 128K program bank; software sets it first
// - bank clear maps to 0-1FFFF, bank set maps to 20000-3FFFF
// - byte at the address goes to the accumulator, next byte to B
// - external forms build a 24-bit address, B as top byte
// - no external data path exists; only the address is produced
// - 64 two-byte pointers live at RAM 0 to 7FH, low byte first
//
package oag_pkg;

    // ------------------------------------------------------------
    // address map and field positions
    // ------------------------------------------------------------
    localparam logic [7:0]  SYS_PAGE       = 8'hFF;
    localparam logic [7:0]  SFR_PAGE       = 8'hFE;
    localparam logic [15:0] RAM_TOP        = 16'hFDFF;
    localparam logic [15:0] PTR_TABLE_BASE = 16'h0000;
    localparam logic [7:0]  BLOCKED_READ   = 8'hFF;
    localparam int          BANK_BIT       = 3;
    localparam int          RAM_BIT8_BIT   = 1;
    localparam int          ROM_AW         = 18;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AREA_RAM = 2'h0,
        AREA_SFR = 2'h1,
        AREA_SYS = 2'h2
    } area_e;

    typedef enum logic [1:0] {
        OP_LOAD  = 2'h0,
        OP_STORE = 2'h1,
        OP_TABLE = 2'h2,
        OP_EXT   = 2'h3
    } op_e;

    typedef enum logic [1:0] {
        MODE_PTR    = 2'h0,
        MODE_IDX    = 2'h1,
        MODE_OFF    = 2'h2,
        MODE_DIRECT = 2'h3
    } mode_e;

    typedef struct packed {
        op_e         op;
        mode_e       mode;
        logic [5:0]  ptr_num;
        logic [6:0]  offset;
        logic [15:0] direct;
        logic [7:0]  wdata;
    } req_s;

    typedef struct packed {
        req_s              req;
        logic [7:0]        idx;
        logic [7:0]        bhi;
        logic [7:0]        processor_status_word;
        logic [15:0]       ptr;
        logic              blk;
        logic [15:0]       ram_addr;
        logic              ram_rd;
        logic              ram_wr;
        logic [7:0]        ram_wdata;
        logic [ROM_AW-1:0] rom_addr;
        logic              rom_rd;
        logic              done;
        logic [7:0]        load_data;
        logic [7:0]        word_b;
        logic [15:0]       eff_addr;
        logic [23:0]       ext_addr;
        logic              ext_req;
        logic              busy;
    } ctx_s;

    localparam ctx_s CTX_RESET = '0;

    // area decode, shared by the displacer and the checks
    function automatic area_e area_of(input logic [15:0] a);
        if (a[15:8] == SYS_PAGE) return AREA_SYS;
        if (a[15:8] == SFR_PAGE) return AREA_SFR;
        return AREA_RAM;
    endfunction

endpackage

/* File: area_displacer.sv */
`timescale 1ns/1ps
module area_displacer
    import oag_pkg::*;
(
    // base and signed displacement
    input  wire logic [15:0] base,
    input  wire logic [7:0]  disp,
    // folded result
    output logic      [15:0] addr,
    output logic             blocked
);

    logic [16:0] sum;

    // ------------------------------------------------------------
    // closed-area displacement
    // ------------------------------------------------------------
    // bit 16 of the sum catches a wrap below zero for a RAM base
    always_comb begin
        sum     = {1'b0, base} + {{9{disp[7]}}, disp};
        addr    = sum[15:0];
        blocked = 1'b0;
        case (area_of(base))
            AREA_RAM: blocked = sum[16] || (sum[15:0] > RAM_TOP);
            AREA_SFR: addr = {SFR_PAGE, sum[7:0]};
            default:  blocked = 1'b1; // system-area base never reaches memory
        endcase
    end

endmodule

/* File: table_address_former.sv */
`timescale 1ns/1ps
module table_address_former
    import oag_pkg::*;
(
    // pointer, displacement and bank
    input  wire logic [15:0]       ptr,
    input  wire logic              bit16,
    input  wire logic              bank,
    input  wire logic [7:0]        disp,
    // program address
    output logic      [ROM_AW-1:0] rom_addr
);

    logic [16:0] sum;

    // ------------------------------------------------------------
    // 17-bit pointer inside the selected bank
    // ------------------------------------------------------------
    // the sum wraps inside the bank rather than spilling into the next one
    always_comb begin
        sum      = {bit16, ptr} + {{9{disp[7]}}, disp};
        rom_addr = {bank, sum};
    end

endmodule

/* File: operand_address_generator.sv */
`timescale 1ns/1ps
module operand_address_generator
    import oag_pkg::*;
(
    // clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              RESETN,
    // request from the core
    input  wire logic              REQ_VALID,
    input  wire req_s              REQ,
    input  wire logic [7:0]        C_REG,
    input  wire logic [7:0]        B_REG,
    input  wire logic [7:0]        PROCESSOR_STATUS_WORD,
    output logic                   BUSY,
    // internal RAM and special registers
    output logic      [15:0]       RAM_ADDR,
    output logic                   RAM_RD,
    output logic                   RAM_WR,
    output logic      [7:0]        RAM_WDATA,
    input  wire logic [7:0]        RAM_RDATA,
    // program ROM
    output logic      [ROM_AW-1:0] ROM_ADDR,
    output logic                   ROM_RD,
    input  wire logic [7:0]        ROM_RDATA,
    // results
    output logic                   DONE,
    output logic      [7:0]        LOAD_DATA,
    output logic      [7:0]        WORD_B,
    output logic      [15:0]       EFF_ADDR,
    output logic      [23:0]       EXT_ADDR,
    output logic                   EXT_REQ
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_PLO  = 10'h002,
        ST_PHI  = 10'h004,
        ST_GHI  = 10'h008,
        ST_CALC = 10'h010,
        ST_MRD  = 10'h020,
        ST_MCAP = 10'h040,
        ST_TLO  = 10'h080,
        ST_THI  = 10'h100,
        ST_TCAP = 10'h200
    } state_e;

    state_e             st_reg;
    state_e             st_next;
    ctx_s               r;
    ctx_s               n;
    logic [7:0]         disp;
    logic [15:0]        disp_addr;
    logic               disp_blk;
    logic [ROM_AW-1:0]  tbl_addr;
    logic [15:0]        ext_low;

    // ------------------------------------------------------------
    // displacement select
    // ------------------------------------------------------------
    // plain pointer and direct forms add nothing
    always_comb begin
        disp = 8'h00;
        case (r.req.mode)
            MODE_IDX: disp = r.idx;
            MODE_OFF: disp = {r.req.offset[6], r.req.offset};
            default:  disp = 8'h00;
        endcase
    end

    // raw sum for the external form, no area folding applies there
    assign ext_low = r.ptr + {{8{disp[7]}}, disp};

    area_displacer u_disp (
        .base    (r.ptr),
        .disp    (disp),
        .addr    (disp_addr),
        .blocked (disp_blk)
    );

    table_address_former u_tbl (
        .ptr      (r.ptr),
        .bit16    (r.processor_status_word[RAM_BIT8_BIT]),
        .bank     (r.processor_status_word[BANK_BIT]),
        .disp     (disp),
        .rom_addr (tbl_addr)
    );

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    // memory reads answer one cycle after the strobe, so each fetch is
    // strobed in one state and captured in the next
    always_comb begin
        n           = r;
        st_next     = st_reg;
        n.done      = 1'b0;
        n.ext_req   = 1'b0;
        n.ram_rd    = 1'b0;
        n.ram_wr    = 1'b0;
        n.rom_rd    = 1'b0;
        case (st_reg)
            ST_IDLE: begin
                n.busy = 1'b0;
                if (REQ_VALID) begin
                    n.req  = REQ;
                    n.idx  = C_REG;
                    n.bhi  = B_REG;
                    n.processor_status_word  = PROCESSOR_STATUS_WORD;
                    n.busy = 1'b1;
                    if (REQ.mode == MODE_DIRECT) begin
                        n.ptr   = REQ.direct;
                        st_next = ST_CALC;
                    end else begin
                        n.ram_addr = PTR_TABLE_BASE + {9'h000, REQ.ptr_num, 1'b0};
                        n.ram_rd   = 1'b1;
                        st_next    = ST_PLO;
                    end
                end
            end
            ST_PLO: begin
                n.ram_addr = r.ram_addr + 16'h0001;
                n.ram_rd   = 1'b1;
                st_next    = ST_PHI;
            end
            ST_PHI: begin
                n.ptr[7:0] = RAM_RDATA;
                st_next    = ST_GHI;
            end
            ST_GHI: begin
                n.ptr[15:8] = RAM_RDATA;
                st_next     = ST_CALC;
            end
            ST_CALC: begin
                n.eff_addr = disp_addr;
                n.blk      = disp_blk;
                case (r.req.op)
                    OP_LOAD: begin
                        if (disp_blk) begin
                            n.load_data = BLOCKED_READ;
                            n.done      = 1'b1;
                            n.busy      = 1'b0;
                            st_next     = ST_IDLE;
                        end else begin
                            n.ram_addr = disp_addr;
                            n.ram_rd   = 1'b1;
                            st_next    = ST_MRD;
                        end
                    end
                    OP_STORE: begin
                        if (!disp_blk) begin
                            n.ram_addr  = disp_addr;
                            n.ram_wdata = r.req.wdata;
                            n.ram_wr    = 1'b1;
                        end
                        n.done  = 1'b1;
                        n.busy  = 1'b0;
                        st_next = ST_IDLE;
                    end
                    OP_TABLE: begin
                        n.rom_addr = tbl_addr;
                        n.rom_rd   = 1'b1;
                        st_next    = ST_TLO;
                    end
                    default: begin
                        // address only: there is no external data path
                        n.ext_addr = {r.bhi, ext_low};
                        n.ext_req  = 1'b1;
                        n.done     = 1'b1;
                        n.busy     = 1'b0;
                        st_next    = ST_IDLE;
                    end
                endcase
            end
            ST_MRD: begin
                st_next = ST_MCAP;
            end
            ST_MCAP: begin
                n.load_data = RAM_RDATA;
                n.done      = 1'b1;
                n.busy      = 1'b0;
                st_next     = ST_IDLE;
            end
            ST_TLO: begin
                n.rom_addr = r.rom_addr + {{(ROM_AW-1){1'b0}}, 1'b1};
                n.rom_rd   = 1'b1;
                st_next    = ST_THI;
            end
            ST_THI: begin
                n.load_data = ROM_RDATA;
                st_next     = ST_TCAP;
            end
            ST_TCAP: begin
                n.word_b = ROM_RDATA;
                n.done   = 1'b1;
                n.busy   = 1'b0;
                st_next  = ST_IDLE;
            end
            default: begin
                n       = CTX_RESET;
                st_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_reg <= ST_IDLE;
            r      <= CTX_RESET;
        end else begin
            st_reg <= st_next;
            r      <= n;
        end
    end

    // outputs straight from the context flops
    assign BUSY      = r.busy;
    assign RAM_ADDR  = r.ram_addr;
    assign RAM_RD    = r.ram_rd;
    assign RAM_WR    = r.ram_wr;
    assign RAM_WDATA = r.ram_wdata;
    assign ROM_ADDR  = r.rom_addr;
    assign ROM_RD    = r.rom_rd;
    assign DONE      = r.done;
    assign LOAD_DATA = r.load_data;
    assign WORD_B    = r.word_b;
    assign EFF_ADDR  = r.eff_addr;
    assign EXT_ADDR  = r.ext_addr;
    assign EXT_REQ   = r.ext_req;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);

    a_ptr_fetch_pair:
        assert property (st_reg == ST_PLO |->
            RAM_RD && RAM_ADDR == PTR_TABLE_BASE + {9'h000, r.req.ptr_num, 1'b0}
            ##1 RAM_RD && RAM_ADDR == PTR_TABLE_BASE + {9'h000, r.req.ptr_num, 1'b1})
        else $error("pointer fetch address wrong");

    a_idx_sum_ram:
        assert property (st_reg == ST_CALC && r.req.op == OP_LOAD
            && r.req.mode == MODE_IDX && area_of(r.ptr) == AREA_RAM && !disp_blk
            |=> RAM_RD && RAM_ADDR == r.ptr + {{8{r.idx[7]}}, r.idx})
        else $error("indexed address wrong");

    a_area_kept:
        assert property (st_reg == ST_MRD |-> area_of(RAM_ADDR) == area_of(r.ptr))
        else $error("access left base area");

    a_blocked_read_ff:
        assert property (st_reg == ST_CALC && r.req.op == OP_LOAD && disp_blk
            |=> DONE && LOAD_DATA == BLOCKED_READ && !RAM_RD && RAM_ADDR == $past(RAM_ADDR))
        else $error("blocked read not 0FFH");

    a_sfr_wrap_low:
        assert property (st_reg == ST_MRD && area_of(r.ptr) == AREA_SFR
            |-> RAM_ADDR == {SFR_PAGE, 8'(r.ptr[7:0] + disp)})
        else $error("special area wrap wrong");

    a_off_sum_ram:
        assert property (st_reg == ST_MRD && r.req.mode == MODE_OFF
            && area_of(r.ptr) == AREA_RAM
            |-> RAM_ADDR == r.ptr + {{9{r.req.offset[6]}}, r.req.offset})
        else $error("offset address wrong");

    a_direct_addr:
        assert property (st_reg == ST_MRD && r.req.mode == MODE_DIRECT
            |-> RAM_ADDR == r.req.direct)
        else $error("direct address wrong");

    a_tbl_byte_pair:
        assert property (st_reg == ST_TLO |=>
            ROM_RD && ROM_ADDR == ROM_AW'($past(ROM_ADDR) + 1) ##2 DONE)
        else $error("table pair sequence wrong");

    a_tbl_bank_sel:
        assert property (st_reg == ST_TLO |-> ROM_ADDR[ROM_AW-1] == r.processor_status_word[BANK_BIT])
        else $error("table bank wrong");

    a_ext_top_byte:
        assert property (EXT_REQ |-> DONE && EXT_ADDR[23:16] == r.bhi && !RAM_RD)
        else $error("external address wrong");

    a_no_stray_write:
        assert property (st_reg == ST_CALC && r.req.op == OP_STORE && disp_blk
            |=> !RAM_WR && DONE)
        else $error("blocked write reached memory");

endmodule

/* File: oag_mem_model.sv */
`timescale 1ns/1ps
module oag_mem_model
    import oag_pkg::*;
(
    // clock
    input  wire logic              clk,
    // data space
    input  wire logic [15:0]       ram_addr,
    input  wire logic              ram_rd,
    input  wire logic              ram_wr,
    input  wire logic [7:0]        ram_wdata,
    output logic      [7:0]        ram_rdata,
    // program space
    input  wire logic [ROM_AW-1:0] rom_addr,
    input  wire logic              rom_rd,
    output logic      [7:0]        rom_rdata
);
    // ---------------------------------------------------------
    // storage
    // ---------------------------------------------------------
    logic [7:0] ram [0:65535];
    logic [7:0] rom [0:(1<<ROM_AW)-1];

    // distinct patterns, so a wrong address shows up as wrong data
    initial begin
        for (int i = 0; i < 65536; i++) ram[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
        for (int i = 0; i < (1 << ROM_AW); i++) rom[i] = 8'(i) ^ 8'(i >> 9) ^ 8'(i >> 16);
        ram_rdata = 8'h00;
        rom_rdata = 8'h00;
    end

    // ---------------------------------------------------------
    // answers
    // ---------------------------------------------------------
    // data one cycle after the strobe; otherwise the bus toggles so stale samples fail
    always @(posedge clk) begin
        if (ram_wr) ram[ram_addr] <= ram_wdata;
        ram_rdata <= ram_rd ? ram[ram_addr] : ~ram_rdata;
        rom_rdata <= rom_rd ? rom[rom_addr] : ~rom_rdata;
    end
endmodule

/* File: operand_address_generator_tb.sv */
`timescale 1ns/1ps
module operand_address_generator_tb;
    import oag_pkg::*;
    logic             sys_clk, resetn, req_valid, busy, ram_rd, ram_wr, rom_rd, done, ext_req;
    req_s             req;
    logic [7:0]       c_reg, b_reg, processor_status_word, ram_wdata, ram_rdata, rom_rdata, load_data, word_b;
    logic [15:0]      ram_addr, eff_addr, rd_a, fa;
    logic [ROM_AW-1:0] rom_addr;
    logic [23:0]      ext_addr;
    int               errors, cmp_count, cycles, cyc, rd_n, wr_n, ext_n, bsy_n;

    operand_address_generator i_dut (.SYS_CLK(sys_clk), .RESETN(resetn),
        .REQ_VALID(req_valid), .REQ(req), .C_REG(c_reg), .B_REG(b_reg),
        .PROCESSOR_STATUS_WORD(processor_status_word), .BUSY(busy), .RAM_ADDR(ram_addr), .RAM_RD(ram_rd),
        .RAM_WR(ram_wr), .RAM_WDATA(ram_wdata), .RAM_RDATA(ram_rdata), .ROM_ADDR(rom_addr),
        .ROM_RD(rom_rd), .ROM_RDATA(rom_rdata), .DONE(done), .LOAD_DATA(load_data),
        .WORD_B(word_b), .EFF_ADDR(eff_addr), .EXT_ADDR(ext_addr), .EXT_REQ(ext_req));

    oag_mem_model i_mem (.clk(sys_clk), .ram_addr(ram_addr), .ram_rd(ram_rd),
        .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_rdata(rom_rdata));

    // ---------------------------------------------------------
    // clock, timeout and shared tasks
    // ---------------------------------------------------------
    always #5 sys_clk = ~sys_clk;

    // a hung handshake ends the run here rather than never
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report;
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // pointer n stored low byte first at 2n
    task automatic setp(input int n, input logic [15:0] v);
        i_mem.ram[2*n] = v[7:0];
        i_mem.ram[2*n+1] = v[15:8];
    endtask

    // one request from idle; counts strobes seen until done
    task automatic run(input op_e o, input mode_e m, input logic [5:0] n,
                       input logic [6:0] off, input logic [15:0] dir, input logic [7:0] c);
        @(negedge sys_clk);
        req.op = o;
        req.mode = m;
        req.ptr_num = n;
        req.offset = off;
        req.direct = dir;
        c_reg = c;
        req_valid = 1'b1;
        cyc = 0;
        rd_n = 0;
        wr_n = 0;
        ext_n = 0;
        bsy_n = 0;
        // first sample is the cycle right after the take edge, first fetch included
        do begin
            @(negedge sys_clk);
            req_valid = 1'b0;
            cyc++;
            if (busy === 1'b1) bsy_n++;
            if (ram_rd === 1'b1) begin
                if (rd_n == 0) fa = ram_addr;
                rd_n++;
                rd_a = ram_addr;
            end
            if (ram_wr === 1'b1) wr_n++;
            if (ext_req === 1'b1) ext_n++;
        end while (done !== 1'b1 && cyc < 30);
    endtask

    // ---------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------
    task automatic t_index;
        setp(5, 16'h0123);
        run(OP_LOAD, MODE_IDX, 6'd5, 7'h00, 16'h0, 8'h02);
        chk(24'(fa), 24'h00000A);
        chk(24'(eff_addr), 24'h000125);
        chk(24'(load_data), 24'(i_mem.ram[16'h0125]));
        chk(24'(cyc), 24'd7);
        chk(24'(bsy_n), 24'd6);
        run(OP_LOAD, MODE_IDX, 6'd5, 7'h00, 16'h0, 8'hFF);
        chk(24'(eff_addr), 24'h000122);
        setp(5, 16'h0100);
        run(OP_LOAD, MODE_IDX, 6'd5, 7'h00, 16'h0, 8'h80);
        chk(24'(eff_addr), 24'h000080);
    endtask

    task automatic t_fence;
        setp(6, 16'hFDFF);
        run(OP_LOAD, MODE_IDX, 6'd6, 7'h00, 16'h0, 8'h01);
        chk(24'(load_data), 24'h0000FF);
        chk(24'(rd_n), 24'd2);
        ram_wdata_probe(6);
        setp(6, 16'h0000);
        run(OP_LOAD, MODE_IDX, 6'd6, 7'h00, 16'h0, 8'h80);
        chk(24'(load_data), 24'h0000FF);
        setp(6, 16'hFF10);
        run(OP_LOAD, MODE_IDX, 6'd6, 7'h00, 16'h0, 8'h01);
        chk(24'(load_data), 24'h0000FF);
    endtask

    // out-of-area store must leave every location alone
    task automatic ram_wdata_probe(input int n);
        logic [7:0] keep;
        keep = i_mem.ram[16'hFE00];
        req.wdata = 8'h5A;
        run(OP_STORE, MODE_IDX, 6'(n), 7'h00, 16'h0, 8'h01);
        chk(24'(wr_n), 24'd0);
        chk(24'(i_mem.ram[16'hFE00]), 24'(keep));
    endtask

    task automatic t_sfr_offset;
        setp(7, 16'hFEFF);
        run(OP_LOAD, MODE_IDX, 6'd7, 7'h00, 16'h0, 8'h02);
        chk(24'(eff_addr), 24'h00FE01);
        chk(24'(load_data), 24'(i_mem.ram[16'hFE01]));
        setp(0, 16'hFEFF);
        run(OP_LOAD, MODE_OFF, 6'd0, 7'h02, 16'h0, 8'h00);
        chk(24'(eff_addr), 24'h00FE01);
        setp(0, 16'h0123);
        run(OP_LOAD, MODE_OFF, 6'd0, 7'h10, 16'h0, 8'h00);
        chk(24'(eff_addr), 24'h000133);
        chk(24'(load_data), 24'(i_mem.ram[16'h0133]));
        run(OP_LOAD, MODE_OFF, 6'd0, 7'h40, 16'h0, 8'h00);
        chk(24'(eff_addr), 24'h0000E3);
        run(OP_LOAD, MODE_OFF, 6'd0, 7'h3F, 16'h0, 8'h00);
        chk(24'(eff_addr), 24'h000162);
    endtask

    task automatic t_direct;
        run(OP_LOAD, MODE_DIRECT, 6'd0, 7'h00, 16'h0123, 8'h00);
        chk(24'(load_data), 24'(i_mem.ram[16'h0123]));
        chk(24'(cyc), 24'd4);
        req.wdata = 8'hA5;
        run(OP_STORE, MODE_DIRECT, 6'd0, 7'h00, 16'h0200, 8'h00);
        chk(24'(cyc), 24'd2);
        chk(24'(bsy_n), 24'd1);
        // the memory takes the write on the edge after the strobe cycle
        @(negedge sys_clk);
        chk(24'(i_mem.ram[16'h0200]), 24'h0000A5);
    endtask

    task automatic t_table;
        setp(0, 16'h1234);
        processor_status_word = 8'h0A; // bank set, address bit 16 copied in first
        run(OP_TABLE, MODE_OFF, 6'd0, 7'h01, 16'h0, 8'h00);
        chk(24'(load_data), 24'(i_mem.rom[18'h31235]));
        chk(24'(word_b), 24'(i_mem.rom[18'h31236]));
        setp(3, 16'hFFFF);
        processor_status_word = 8'h00;
        run(OP_TABLE, MODE_IDX, 6'd3, 7'h00, 16'h0, 8'h01);
        chk(24'(load_data), 24'(i_mem.rom[18'h10000]));
        chk(24'(word_b), 24'(i_mem.rom[18'h10001]));
    endtask

    task automatic t_ext;
        setp(0, 16'h3456);
        b_reg = 8'h12;
        run(OP_EXT, MODE_OFF, 6'd0, 7'h01, 16'h0, 8'h00);
        chk(24'(ext_n), 24'd1);
        chk(ext_addr, 24'h123457);
        chk(24'(rd_n + wr_n), 24'd2);
        // plain pointer form ignores both offset and index
        run(OP_EXT, MODE_PTR, 6'd0, 7'h3F, 16'h0, 8'h05);
        chk(ext_addr, 24'h123456);
    endtask

    // ---------------------------------------------------------
    // main sequence and verdict
    // ---------------------------------------------------------
    task automatic final_report;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        c_reg = 8'h00;
        b_reg = 8'h00;
        processor_status_word = 8'h00;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        t_index;
        t_fence;
        t_sfr_offset;
        t_direct;
        t_table;
        t_ext;
        final_report;
    end
endmodule
